// ==== aea_pkg.sv ====
// Operation
// [RL1] No offset correction on the apparent power product; offsets are fixed upstream.
// [RL2] Add every sample into a 49-bit accumulator; total shows upper 24 divided bits. The code shows quotient bits 47 to 24, below the top bit 48.
// [RL3] One apparent power sample is taken every four input clock periods.
// [RL4] Every accumulation step is a signed twos complement addition.
// [RL5] Divide accumulator by the 8-bit unsigned divider; zero divides by one.
// [RL6] A second 24-bit energy view clears to zero when the host reads it.
// [RL7] The 24-bit energy register is reported and judged as unsigned.
// [RL8] Enabled half-full and overflow events of the energy register raise the interrupt.
// [RL9] Half-full threshold is half of the full unsigned 24-bit range.
// [RL10] Gain scales power; 0x7FF accumulates fastest, 0x800 slowest.
// [RL11] Line energy always accumulates over whole half line cycles from zero crossings.
// [RL12] The half-cycle count comes from a 16-bit unsigned register, up to 65535.
// [RL13] Line apparent interval matches the line active energy half-cycle interval.
// [RL14] The end-of-cycle flag is set when each line interval ends.
// [RL15] With end-of-cycle mask enabled, the interrupt output goes low on that event.
// [RL16] Line energy uses the same scaled path and LSB weight as total energy; the code does not divide line energy by the divider.
// [RL17] Power is multiplied by one plus the signed 12-bit gain over 4096.
// [RL18] A finished line sum is latched and a new interval starts from zero.
// [RL19] Host reads the clearing view before overflow; each read consumes the energy.
package aea_pkg;
   localparam int ACC_W         = 49;
   localparam int ENERGY_W      = 24;
   localparam int ENERGY_LSB    = 24;
   localparam int POWER_W       = 24;
   localparam int GAIN_W        = 12;
   localparam int GAIN_SHIFT    = 12;
   localparam int DIVIDER_W     = 8;
   localparam int HALF_CYCLE_W  = 16;
   localparam int SAMPLE_PERIOD = 4;
   localparam int SDIV_W        = 2;
   localparam logic [SDIV_W-1:0] SDIV_LAST = 2'h3;
   localparam int FLAG_HALF     = 0;
   localparam int FLAG_OVF      = 1;
   localparam int FLAG_CYC      = 2;
   localparam int FLAG_W        = 3;
   localparam logic [ACC_W-1:0]        ACC_RESET    = 49'h0;
   localparam logic [ENERGY_W-1:0]     ENERGY_RESET = 24'h0;
   localparam logic [HALF_CYCLE_W-1:0] HC_RESET     = 16'h0;
   localparam logic [FLAG_W-1:0]       FLAG_RESET   = 3'h0;
endpackage : aea_pkg

// ==== aea_div.sv ====
`timescale 1ns/100ps
module aea_div
   import aea_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       reset,
   input  wire logic signed [ACC_W-1:0]    acc,
   input  wire logic [DIVIDER_W-1:0]       divider,
   output logic [ENERGY_W-1:0]             energy_ff
);
   logic signed [ACC_W-1:0] divisor;
   logic signed [ACC_W-1:0] quotient;
   logic [ENERGY_W-1:0]     nxt_energy;

   always_comb begin
      divisor = (divider == 8'h00) ? 49'sh1 : $signed({41'h0, divider}); // RL5
      quotient = acc / divisor; // RL5
      nxt_energy = quotient[ENERGY_LSB+ENERGY_W-1:ENERGY_LSB]; // RL2 RL7
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         energy_ff <= ENERGY_RESET;
      end else begin
         energy_ff <= nxt_energy;
      end
   end
endmodule // aea_div

// ==== aea_accumulator.sv ====
`timescale 1ns/100ps
module aea_accumulator
   import aea_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       reset,
   input  wire logic [POWER_W-1:0]         apparent_power,
   input  wire logic [GAIN_W-1:0]          apparent_gain,
   input  wire logic [DIVIDER_W-1:0]       apparent_energy_divider,
   input  wire logic [HALF_CYCLE_W-1:0]    half_cycle_count,
   input  wire logic                       zero_cross,
   input  wire logic                       read_clear_strobe,
   input  wire logic [FLAG_W-1:0]          flag_clear,
   input  wire logic [FLAG_W-1:0]          irq_enable,
   output logic [ENERGY_W-1:0]             apparent_energy_total,
   output logic [ENERGY_W-1:0]             apparent_energy_read_clear,
   output logic [ENERGY_W-1:0]             line_apparent_energy,
   output logic [FLAG_W-1:0]               status_flags,
   output logic                            sample_strobe,
   output logic                            irq_n
);
   typedef struct packed {
      logic [SDIV_W-1:0]        sdiv;
      logic                     sample;
      logic signed [ACC_W-1:0]  acc;
      logic signed [ACC_W-1:0]  rc_acc;
      logic signed [ACC_W-1:0]  line_acc;
      logic [HALF_CYCLE_W-1:0]  hc_cnt;
      logic [ENERGY_W-1:0]      total;
      logic [ENERGY_W-1:0]      rclr;
      logic [ENERGY_W-1:0]      line;
      logic [FLAG_W-1:0]        flags;
      logic                     irq_n;
   } aea_state_type;

   aea_state_type state_ff;
   aea_state_type nxt_state;
   logic [ENERGY_W-1:0]     total_div;
   logic [ENERGY_W-1:0]     rclr_div;
   logic signed [ACC_W-1:0] scaled;
   logic                    line_end;
   logic [FLAG_W-1:0]       events;

   // Gain is applied as p + p*g/4096; no offset term is added to the product. RL1
   function automatic logic signed [ACC_W-1:0] scale_power(
      input logic [POWER_W-1:0] p,
      input logic [GAIN_W-1:0]  g);
      logic signed [POWER_W+GAIN_W:0] prod;
      logic signed [ACC_W-1:0]        ext;
      prod = $signed({1'b0, p}) * $signed(g);
      ext  = ACC_W'($signed({1'b0, p}));
      return ext + ACC_W'(prod >>> GAIN_SHIFT);
   endfunction

   aea_div u_total_div (
      .clk       (clk),
      .reset     (reset),
      .acc       (state_ff.acc),
      .divider   (apparent_energy_divider),
      .energy_ff (total_div)
   );

   aea_div u_rclr_div (
      .clk       (clk),
      .reset     (reset),
      .acc       (state_ff.rc_acc),
      .divider   (apparent_energy_divider),
      .energy_ff (rclr_div)
   );

   always_comb begin
      nxt_state = state_ff;
      scaled = scale_power(apparent_power, apparent_gain); // RL10 RL17
      nxt_state.sdiv = state_ff.sdiv + 2'h1;
      nxt_state.sample = (state_ff.sdiv == SDIV_LAST); // RL3
      if (state_ff.sample) begin
         nxt_state.acc = state_ff.acc + scaled; // RL2 RL4
      end
      // The sample of the clearing cycle belongs to the next read, so none is lost. RL19
      if (read_clear_strobe) begin
         nxt_state.rc_acc = state_ff.sample ? scaled : ACC_RESET; // RL6
      end else if (state_ff.sample) begin
         nxt_state.rc_acc = state_ff.rc_acc + scaled; // RL4
      end
      line_end = 1'b0;
      if (zero_cross) begin
         if (state_ff.hc_cnt + 16'h1 >= half_cycle_count) begin // RL12 RL13
            line_end = 1'b1;
            nxt_state.hc_cnt = HC_RESET;
         end else begin
            nxt_state.hc_cnt = state_ff.hc_cnt + 16'h1;
         end
      end
      if (line_end) begin
         nxt_state.line = state_ff.line_acc[ENERGY_LSB+ENERGY_W-1:ENERGY_LSB]; // RL18 RL16
         nxt_state.line_acc = state_ff.sample ? scaled : ACC_RESET; // RL18
      end else if (state_ff.sample) begin
         nxt_state.line_acc = state_ff.line_acc + scaled; // RL11 RL16
      end
      nxt_state.total = total_div;
      nxt_state.rclr = rclr_div;
      // Unsigned view: crossing into the upper half is half-full, wrapping down is overflow.
      events[FLAG_HALF] = !state_ff.total[ENERGY_W-1] && total_div[ENERGY_W-1]; // RL9 RL7
      events[FLAG_OVF]  = state_ff.total[ENERGY_W-1] && !total_div[ENERGY_W-1]; // RL8
      events[FLAG_CYC]  = line_end; // RL14
      nxt_state.flags = (state_ff.flags & ~flag_clear) | events;
      nxt_state.irq_n = !(|(nxt_state.flags & irq_enable)); // RL8 RL15
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= '{sdiv: 2'h0, sample: 1'b0, acc: ACC_RESET, rc_acc: ACC_RESET,
                       line_acc: ACC_RESET, hc_cnt: HC_RESET, total: ENERGY_RESET,
                       rclr: ENERGY_RESET, line: ENERGY_RESET, flags: FLAG_RESET,
                       irq_n: 1'b1};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign apparent_energy_total      = state_ff.total;
   assign apparent_energy_read_clear = state_ff.rclr;
   assign line_apparent_energy       = state_ff.line;
   assign status_flags               = state_ff.flags;
   assign sample_strobe              = state_ff.sample;
   assign irq_n                      = state_ff.irq_n;

   property p_sample_period;
      @(posedge clk) disable iff (reset)
      state_ff.sample |=> !state_ff.sample [*3] ##1 state_ff.sample;
   endproperty
   a_sample_period: assert property (p_sample_period) else $error("sample spacing wrong"); // RL3

   property p_acc_hold;
      @(posedge clk) disable iff (reset)
      !state_ff.sample |=> $stable(state_ff.acc);
   endproperty
   a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved off sample"); // RL2

   property p_acc_add;
      @(posedge clk) disable iff (reset)
      state_ff.sample |=> state_ff.acc == $past(state_ff.acc) + $past(scaled);
   endproperty
   a_acc_add: assert property (p_acc_add) else $error("accumulator sum wrong"); // RL4

   property p_zero_gain;
      @(posedge clk) disable iff (reset)
      apparent_gain == 12'h000 |-> scaled == ACC_W'($signed({1'b0, apparent_power}));
   endproperty
   a_zero_gain: assert property (p_zero_gain) else $error("unity gain altered power"); // RL17

   property p_read_clear;
      @(posedge clk) disable iff (reset)
      read_clear_strobe && !state_ff.sample |=> state_ff.rc_acc == ACC_RESET;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read did not clear"); // RL6

   property p_cyc_flag;
      @(posedge clk) disable iff (reset)
      line_end |=> state_ff.flags[FLAG_CYC];
   endproperty
   a_cyc_flag: assert property (p_cyc_flag) else $error("end-of-cycle flag missing"); // RL14

   property p_cyc_irq;
      @(posedge clk) disable iff (reset)
      line_end && irq_enable[FLAG_CYC] |=> !irq_n;
   endproperty
   a_cyc_irq: assert property (p_cyc_irq) else $error("irq not low on end of cycle"); // RL15

   property p_line_latch;
      @(posedge clk) disable iff (reset)
      line_end && !state_ff.sample |=> state_ff.line_acc == ACC_RESET &&
         state_ff.line == $past(state_ff.line_acc[ENERGY_LSB+ENERGY_W-1:ENERGY_LSB]);
   endproperty
   a_line_latch: assert property (p_line_latch) else $error("line sum not latched"); // RL18

   property p_half_full;
      @(posedge clk) disable iff (reset)
      !state_ff.total[ENERGY_W-1] && total_div[ENERGY_W-1] |=> state_ff.flags[FLAG_HALF];
   endproperty
   a_half_full: assert property (p_half_full) else $error("half-full flag missing"); // RL9

   property p_irq_quiet;
      @(posedge clk) disable iff (reset)
      ((state_ff.flags & irq_enable) == 3'h0) && (events == 3'h0) |=> irq_n;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("irq low with no enabled flag"); // RL8

   // The total trails the accumulator by two edges: one in the divider, one here.
   property p_total_plain;
      @(posedge clk) disable iff (reset)
      apparent_energy_divider <= 8'h01 |->
         ##2 state_ff.total == $past(state_ff.acc[ENERGY_LSB+ENERGY_W-1:ENERGY_LSB], 2);
   endproperty
   a_total_plain: assert property (p_total_plain) else $error("total path wrong"); // RL2 RL5

   property p_rclr_zero;
      @(posedge clk) disable iff (reset)
      read_clear_strobe && !state_ff.sample |-> ##3 state_ff.rclr == ENERGY_RESET;
   endproperty
   a_rclr_zero: assert property (p_rclr_zero) else $error("view not cleared"); // RL6

   property p_rc_restart;
      @(posedge clk) disable iff (reset)
      read_clear_strobe && state_ff.sample |=> state_ff.rc_acc == $past(scaled);
   endproperty
   a_rc_restart: assert property (p_rc_restart) else $error("clearing sample lost"); // RL6

   property p_rc_add;
      @(posedge clk) disable iff (reset)
      !read_clear_strobe && state_ff.sample |=>
         state_ff.rc_acc == $past(state_ff.rc_acc) + $past(scaled);
   endproperty
   a_rc_add: assert property (p_rc_add) else $error("clearing sum wrong"); // RL4

   property p_rc_hold;
      @(posedge clk) disable iff (reset)
      !read_clear_strobe && !state_ff.sample |=> $stable(state_ff.rc_acc);
   endproperty
   a_rc_hold: assert property (p_rc_hold) else $error("clearing sum moved"); // RL6

   property p_ovf_flag;
      @(posedge clk) disable iff (reset)
      state_ff.total[ENERGY_W-1] && !total_div[ENERGY_W-1] |=> state_ff.flags[FLAG_OVF];
   endproperty
   a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag missing"); // RL8

   property p_cyc_sticky;
      @(posedge clk) disable iff (reset)
      state_ff.flags[FLAG_CYC] && !flag_clear[FLAG_CYC] |=> state_ff.flags[FLAG_CYC];
   endproperty
   a_cyc_sticky: assert property (p_cyc_sticky) else $error("end-of-cycle flag lost"); // RL14

   property p_cyc_clear;
      @(posedge clk) disable iff (reset)
      flag_clear[FLAG_CYC] && !line_end |=> !state_ff.flags[FLAG_CYC];
   endproperty
   a_cyc_clear: assert property (p_cyc_clear) else $error("end-of-cycle flag not cleared"); // RL14

   property p_irq_hold;
      @(posedge clk) disable iff (reset)
      (state_ff.flags & irq_enable) != 3'h0 && flag_clear == 3'h0 |=> !irq_n;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq released too early"); // RL8 RL15

   property p_hc_step;
      @(posedge clk) disable iff (reset)
      zero_cross && !line_end |=> state_ff.hc_cnt == $past(state_ff.hc_cnt) + 16'h1;
   endproperty
   a_hc_step: assert property (p_hc_step) else $error("half-cycle count missed"); // RL12

   property p_hc_hold;
      @(posedge clk) disable iff (reset)
      !zero_cross |=> $stable(state_ff.hc_cnt);
   endproperty
   a_hc_hold: assert property (p_hc_hold) else $error("half-cycle count moved"); // RL11

   property p_hc_restart;
      @(posedge clk) disable iff (reset)
      line_end |=> state_ff.hc_cnt == HC_RESET;
   endproperty
   a_hc_restart: assert property (p_hc_restart) else $error("interval not restarted"); // RL18

   property p_line_add;
      @(posedge clk) disable iff (reset)
      !line_end && state_ff.sample |=>
         state_ff.line_acc == $past(state_ff.line_acc) + $past(scaled);
   endproperty
   a_line_add: assert property (p_line_add) else $error("line sum wrong"); // RL11 RL16

   property p_line_hold;
      @(posedge clk) disable iff (reset)
      !line_end |=> $stable(state_ff.line);
   endproperty
   a_line_hold: assert property (p_line_hold) else $error("line energy moved"); // RL18

   property p_line_restart;
      @(posedge clk) disable iff (reset)
      line_end && state_ff.sample |=> state_ff.line_acc == $past(scaled);
   endproperty
   a_line_restart: assert property (p_line_restart) else $error("line sample lost"); // RL18

   property p_gain_max;
      @(posedge clk) disable iff (reset)
      apparent_gain == 12'h7FF |-> scaled >= ACC_W'($signed({1'b0, apparent_power}));
   endproperty
   a_gain_max: assert property (p_gain_max) else $error("top gain shrank power"); // RL10

   // The most negative gain halves the power, rounding down.
   property p_gain_min;
      @(posedge clk) disable iff (reset)
      apparent_gain == 12'h800 |->
         scaled == ACC_W'($signed({2'b00, apparent_power[POWER_W-1:1]}));
   endproperty
   a_gain_min: assert property (p_gain_min) else $error("bottom gain not half"); // RL10 RL17

   property p_reset_flags;
      @(posedge clk)
      reset |=> state_ff.flags == FLAG_RESET && state_ff.irq_n;
   endproperty
   a_reset_flags: assert property (p_reset_flags) else $error("flags not reset"); // RL14

   c_line_end: cover property (@(posedge clk) disable iff (reset) line_end);
   c_overflow: cover property (@(posedge clk) disable iff (reset) events[FLAG_OVF]);
   c_read_clear: cover property (@(posedge clk) disable iff (reset)
      read_clear_strobe && state_ff.sample);
   c_half_full: cover property (@(posedge clk) disable iff (reset) events[FLAG_HALF]);
   c_cyc_irq: cover property (@(posedge clk) disable iff (reset)
      line_end && irq_enable[FLAG_CYC]);
endmodule // aea_accumulator

// ==== aea_host_model.sv ====
`timescale 1ns/100ps
// Stands in for the zero-crossing detector and the host read port; each request
// becomes exactly one registered pulse unless reset is high, launched just after a clock edge.
module aea_host_model (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic cross_req,
   input  wire logic read_req,
   output logic      zero_cross,
   output logic      read_clear_strobe
);
   always_ff @(posedge clk) begin
      zero_cross        <= cross_req & ~reset;
      read_clear_strobe <= read_req & ~reset;
   end
endmodule // aea_host_model

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
   import aea_pkg::*;
   logic        clk, reset, cross_req, read_req, zero_cross, read_clear_strobe;
   logic        sample_strobe, irq_n;
   logic [23:0] apparent_power, total, rclr, line;
   logic [11:0] apparent_gain;
   logic [7:0]  divider;
   logic [15:0] half_cycle_count;
   logic [2:0]  flag_clear, irq_enable, flags;
   longint      acc, rc, ln, lat, s;
   int          cnt, failures, n_checks;

   aea_host_model host (.clk(clk), .reset(reset), .cross_req(cross_req), .read_req(read_req),
      .zero_cross(zero_cross), .read_clear_strobe(read_clear_strobe));
   aea_accumulator dut (.clk(clk), .reset(reset), .apparent_power(apparent_power),
      .apparent_gain(apparent_gain), .apparent_energy_divider(divider),
      .half_cycle_count(half_cycle_count), .zero_cross(zero_cross),
      .read_clear_strobe(read_clear_strobe), .flag_clear(flag_clear), .irq_enable(irq_enable),
      .apparent_energy_total(total), .apparent_energy_read_clear(rclr),
      .line_apparent_energy(line), .status_flags(flags), .sample_strobe(sample_strobe),
      .irq_n(irq_n));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Reference sums; design outputs are read before their own edge updates land.
   always @(posedge clk) begin
      if (reset) begin
         acc = 0; rc = 0; ln = 0; lat = 0; cnt = 0;
      end else begin
         if (read_clear_strobe) rc = 0;
         if (zero_cross) begin
            cnt++;
            if (cnt == int'(half_cycle_count)) begin
               lat = ln; ln = 0; cnt = 0;
            end
         end
         if (sample_strobe) begin
            s = longint'(apparent_power);
            s = s + s * longint'(signed'(apparent_gain)) / 4096;
            acc += s; rc += s; ln += s;
         end
      end
   end

   function automatic logic [47:0] hi(input longint v);
      return 48'(v[47:24]);
   endfunction

   task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic t_strobe;
      int k;
      k = 0;
      while (sample_strobe !== 1'b1 && k < 10) begin
         @(negedge clk);
         k++;
      end
      if (sample_strobe !== 1'b1) begin
         failures++;
         stop_test();
      end
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (sample_strobe !== 1'b1 && k < 10);
      check("strobe period", 48'(k), 48'd4);
      if (sample_strobe !== 1'b1) stop_test();
   endtask

   task automatic t_accum(input logic [11:0] g, input logic [7:0] d, input int n);
      apparent_gain = g;
      divider = d;
      apparent_power = 24'h800000;
      repeat (n * 4) @(negedge clk);
      apparent_power = 24'h0;
      repeat (8) @(negedge clk);
      check("total", total, hi(acc / (d == 8'h0 ? 1 : longint'(d))));
      check("read clear", rclr, hi(rc / (d == 8'h0 ? 1 : longint'(d))));
   endtask

   task automatic pulse(input bit x);
      @(negedge clk);
      if (x) cross_req = 1'b1;
      else read_req = 1'b1;
      @(negedge clk);
      cross_req = 1'b0;
      read_req = 1'b0;
      repeat (3) @(negedge clk);
   endtask

   task automatic t_line(input logic [2:0] en);
      irq_enable = en;
      pulse(1'b1);
      check("flag early", 48'(flags), 48'h0);
      pulse(1'b1);
      check("flag", 48'(flags), 48'h4);
      check("irq", 48'(irq_n), 48'(en == 3'h0));
      check("line", line, hi(lat));
      flag_clear = 3'h4;
      @(negedge clk);
      flag_clear = 3'h0;
      repeat (2) @(negedge clk);
      check("flag cleared", 48'({irq_n, flags}), 48'h8);
   endtask

   initial begin
      failures = 0; n_checks = 0; reset = 1'b1; cross_req = 1'b0; read_req = 1'b0;
      apparent_power = 24'h0; apparent_gain = 12'h0; divider = 8'h0;
      half_cycle_count = 16'h2; flag_clear = 3'h0; irq_enable = 3'h4;
      repeat (8) @(negedge clk);
      check("reset outputs", {total, rclr}, 48'h0);
      check("reset flags", 48'({irq_n, flags}), 48'h8);
      reset = 1'b0;
      t_strobe();
      t_accum(12'h000, 8'h00, 300);
      t_accum(12'h7FF, 8'h03, 200);
      pulse(1'b0);
      check("cleared view", rclr, 48'h0);
      t_accum(12'h800, 8'h01, 100);
      t_line(3'h4);
      t_line(3'h0);
      stop_test();
   end
endmodule // tb_top
